/* File: hdl/mpw_pkg.sv */
package mpw_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  // control fields
  localparam int unsigned CTL_EN = 0;
  localparam int unsigned CTL_FORCE = 1;
  localparam int unsigned CTL_MODE_LO = 2;
  localparam int unsigned CTL_PRE_LO = 4;
  localparam int unsigned CTL_OFS_EN = 6;
  localparam int unsigned CTL_W = 7;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // status fields
  localparam int unsigned ST_OUT = 16;
  localparam int unsigned ST_DOWN = 17;
  // prescaler
  localparam int unsigned PRE_W = 6;
  localparam logic [PRE_W-1:0] PRE_DIV1 = 6'h00;
  localparam logic [PRE_W-1:0] PRE_DIV4 = 6'h03;
  localparam logic [PRE_W-1:0] PRE_DIV16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_DIV64 = 6'h3f;
  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    MPW_STANDARD = 2'b00,
    MPW_SET_MATCH = 2'b01,
    MPW_TOGGLE = 2'b10,
    MPW_CENTER = 2'b11
  } mpw_mode_t;
endpackage : mpw_pkg

/* File: hdl/mpw_core.sv */
// Functional notes
// RL1: two-bit mode picks standard, set on match, toggle on match or center-aligned.
// RL2: standard mode sets output when timer equals phase count.
// RL3: standard mode clears output when timer equals duty-cycle count.
// RL4: standard mode restarts timer at zero when it equals period count.
// RL5: offset match event resynchronises timer when offset mode enabled.
// RL6: standard cycle lasts period count plus one ticks.
// RL7: set-on-match mode sets output when timer equals phase count.
// RL8: set-on-match output stays high until force bit cleared or disabled.
// RL9: set-on-match ignores duty; period caps timer, no phase match above it.
// RL10: force bit write reaches output at next clock edge in set-on-match; a phase-match set in the same cycle wins over a clearing write.
// RL11: toggle mode gives 50% square wave, twice standard period, duty ignored.
// RL12: toggle mode toggles after phase-count-set number of period events.
// RL13: toggle mode ignores force bit writes.
// RL14: center mode counts up to period then down to zero, repeating.
// RL15: center mode sets output on up-count match, clears on down-count match.
// RL16: up match is period minus duty; down match is that plus one.
// RL17: center cycle lasts twice period-plus-one ticks.
// RL18: center mode ignores force bit writes.
// RL19: timer advances one per prescaled tick and holds while disabled.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module mpw_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [mpw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [mpw_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // offset-mode logic, same clock
  input wire logic offset_match,
  // waveform
  output logic pwm_out
);
  import mpw_pkg::*;

  // software-visible settings
  logic [CTL_W-1:0] unit_control_register;
  logic [CNT_W-1:0] period_count;
  logic [CNT_W-1:0] duty_cycle_count;
  logic [CNT_W-1:0] phase_count;

  // timer state
  logic [CNT_W-1:0] running_timer_value;
  logic [CNT_W-1:0] period_events;
  logic [PRE_W-1:0] pre_cnt;
  logic count_down;

  // bus capture
  logic [ADDR_W-1:0] aw_addr;
  logic aw_got;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_got;
  logic wr_go;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // decoded control
  logic [PRE_W-1:0] pre_max;
  logic tick;
  logic unit_on;
  mpw_mode_t mode;
  logic [CNT_W-1:0] up_match;
  logic [CNT_W-1:0] down_match;
  logic ctrl_wr;
  logic [CTL_W-1:0] next_ctrl;
  logic som_set;
  logic force_apply;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign unit_on = unit_control_register[CTL_EN];
  assign mode = mpw_mode_t'(unit_control_register[CTL_MODE_LO +: 2]); // RL1
  assign up_match = period_count - duty_cycle_count; // RL16
  assign down_match = up_match + CNT_ONE; // RL16
  assign wr_go = aw_got & w_got & ~s_axi_bvalid;
  assign ctrl_wr = wr_go & (aw_addr == OFS_CTRL);
  assign next_ctrl = CTL_W'(merge({25'h0000000, unit_control_register}, w_data, w_strb));

  // kept outside the mode case so a write that enters set-on-match applies too
  assign som_set = (mode == MPW_SET_MATCH) && tick && (running_timer_value == phase_count) &&
                   (phase_count <= period_count); // RL7 RL9
  assign force_apply = ctrl_wr && next_ctrl[CTL_EN] &&
                       (next_ctrl[CTL_MODE_LO +: 2] == MPW_SET_MATCH); // RL10

  always_comb begin
    wr_hit = 1'b1;
    unique case (aw_addr)
      OFS_CTRL, OFS_PERIOD, OFS_DUTY, OFS_PHASE: wr_hit = 1'b1;
      // status is read-only, so writes to it answer slverr
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL: rd_word[CTL_W-1:0] = unit_control_register;
      OFS_PERIOD: rd_word[CNT_W-1:0] = period_count;
      OFS_DUTY: rd_word[CNT_W-1:0] = duty_cycle_count;
      OFS_PHASE: rd_word[CNT_W-1:0] = phase_count;
      OFS_STATUS: begin
        rd_word[CNT_W-1:0] = running_timer_value;
        rd_word[ST_OUT] = pwm_out;
        rd_word[ST_DOWN] = count_down;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      // bready may lead bvalid; the answer drops only once it stood
      s_axi_bvalid <= 1'b0;
    end
  end

  // read: one outstanding, arready drops until rdata is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= ~s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_control_register <= CTL_RESET;
    end else if (ctrl_wr) begin
      unit_control_register <= next_ctrl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_count <= CNT_RESET;
      duty_cycle_count <= CNT_RESET;
      phase_count <= CNT_RESET;
    end else if (wr_go) begin
      if (aw_addr == OFS_PERIOD) begin
        period_count <= CNT_W'(merge({16'h0000, period_count}, w_data, w_strb));
      end
      if (aw_addr == OFS_DUTY) begin
        duty_cycle_count <= CNT_W'(merge({16'h0000, duty_cycle_count}, w_data, w_strb));
      end
      if (aw_addr == OFS_PHASE) begin
        phase_count <= CNT_W'(merge({16'h0000, phase_count}, w_data, w_strb));
      end
    end
  end

  // prescaler: 1, 4, 16 or 64 module clocks per tick
  always_comb begin
    unique case (unit_control_register[CTL_PRE_LO +: 2])
      2'b00: pre_max = PRE_DIV1;
      2'b01: pre_max = PRE_DIV4;
      2'b10: pre_max = PRE_DIV16;
      2'b11: pre_max = PRE_DIV64;
    endcase
  end

  assign tick = unit_on && (pre_cnt >= pre_max);

  always_ff @(posedge aclk) begin
    // cleared while off so the first tick after enable is a full one
    if (!aresetn || !unit_on || tick) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  // running timer; center mode dwells one tick at each end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_timer_value <= CNT_RESET;
      count_down <= 1'b0;
    end else if (unit_on && unit_control_register[CTL_OFS_EN] && offset_match) begin
      // offset wins over tick: a resync starts a clean cycle
      running_timer_value <= CNT_RESET; // RL5
      count_down <= 1'b0;
    end else if (tick) begin // RL19
      if (mode == MPW_CENTER) begin
        if (!count_down) begin // RL14
          if (running_timer_value >= period_count) begin
            count_down <= 1'b1; // RL17
          end else begin
            running_timer_value <= running_timer_value + CNT_ONE;
          end
        end else if (running_timer_value == CNT_RESET) begin
          count_down <= 1'b0; // RL17
        end else begin
          running_timer_value <= running_timer_value - CNT_ONE; // RL14
        end
      end else if (running_timer_value >= period_count) begin
        running_timer_value <= CNT_RESET; // RL4 RL6 RL9
        count_down <= 1'b0;
      end else begin
        running_timer_value <= running_timer_value + CNT_ONE; // RL19
        count_down <= 1'b0;
      end
    end
  end

  // period events for toggle mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !unit_on || mode != MPW_TOGGLE) begin
      period_events <= CNT_RESET;
    end else if (tick && running_timer_value >= period_count) begin
      if (period_events >= phase_count) begin
        period_events <= CNT_RESET; // RL12
      end else begin
        period_events <= period_events + CNT_ONE; // RL12
      end
    end
  end

  // output; duty clear wins over phase set when both match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out <= 1'b0;
    end else if (som_set) begin
      // hardware set wins over a clearing write in the same cycle
      pwm_out <= 1'b1; // RL7 RL9
    end else if (force_apply) begin
      pwm_out <= next_ctrl[CTL_FORCE]; // RL10 RL8
    end else if (!unit_on) begin
      pwm_out <= 1'b0; // RL8
    end else begin
      unique case (mode)
        MPW_STANDARD: begin
          if (tick && running_timer_value == duty_cycle_count) begin
            pwm_out <= 1'b0; // RL3
          end else if (tick && running_timer_value == phase_count) begin
            pwm_out <= 1'b1; // RL2
          end
        end
        MPW_SET_MATCH: begin
          // level holds between set and force events
        end
        MPW_TOGGLE: begin
          // force bit not looked at here
          if (tick && running_timer_value >= period_count &&
              period_events >= phase_count) begin
            pwm_out <= ~pwm_out; // RL11 RL12 RL13
          end
        end
        MPW_CENTER: begin
          if (tick && !count_down && running_timer_value == up_match) begin
            pwm_out <= 1'b1; // RL15 RL18
          end else if (tick && count_down && running_timer_value == down_match) begin
            pwm_out <= 1'b0; // RL15
          end
        end
      endcase
    end
  end
endmodule : mpw_core

/* File: tb/mpw_chk.sv */
`timescale 1ns/10ps
module mpw_chk import mpw_pkg::*; (
  // clock, reset, handshakes and waveform
  input logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input logic s_axi_rready, pwm_out,
  // payloads
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic [31:0] s_axi_wdata, s_axi_rdata,
  input logic [1:0] s_axi_bresp
);
  logic [ADDR_W-1:0] wa;
  logic [6:0] ctl;
  wire wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // shadow leads the design by one edge, so checks allow slack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa <= 8'h00;
      ctl <= 7'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wa <= s_axi_awaddr;
      end
      if (wtake && s_axi_awaddr == OFS_CTRL) begin
        ctl <= s_axi_wdata[6:0];
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    wtake;
  endsequence
  sequence s_som_force;
    s_wr_take ##0 (s_axi_awaddr == OFS_CTRL && s_axi_wdata[3:0] == 4'h7);
  endsequence
  a_b_follow: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_follow: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_bad_addr: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == ((wa > OFS_PHASE || wa[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY))
    else $error("wrong write answer");
  a_off_low: assert property ((!ctl[CTL_EN])[*3] |-> !pwm_out)
    else $error("output active while off");
  a_som_set: assert property (s_som_force |-> ##[1:2] pwm_out)
    else $error("force not applied");
endmodule : mpw_chk
bind mpw_core mpw_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pwm_out, .s_axi_awaddr, .s_axi_wdata, .s_axi_rdata, .s_axi_bresp);

/* File: tb/mpw_sw.sv */
`timescale 1ns/10ps
module mpw_sw import mpw_pkg::*; (
  // clock
  input logic aclk,
  // requests
  output logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  // answers
  input logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
  end
  // answers are taken slowly at random, so held responses get exercised
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = $urandom_range(2);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    repeat (n) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    n = $urandom_range(2);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (n) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : mpw_sw

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import mpw_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, offset_match = 1'b0, pw_q = 1'b0, ofs_on = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pwm_out;
  int mismatches = 0, samples_checked = 0, cyc = 0, t_rise = 0;
  logic [33:0] q_rd[$];
  logic [1:0] q_b[$];
  int q_per[$], q_hi[$];
  always #20 aclk = ~aclk;
  mpw_core dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .offset_match, .pwm_out);
  mpw_sw sw_u (.aclk, .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rready, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid);
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // monitor: answers and waveform edges against the oldest note
  always @(posedge aclk) begin
    cyc = cyc + 1;
    offset_match <= ofs_on && (cyc % 7 == 0);
    if (s_axi_rvalid && s_axi_rready) chk("read", q_rd.pop_front(), {s_axi_rdata, s_axi_rresp});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(q_b.pop_front()), 34'(s_axi_bresp));
    if (pwm_out && !pw_q) begin
      if (q_per.size() > 0) chk("period", 34'(q_per.pop_front()), 34'(cyc - t_rise));
      t_rise = cyc;
    end
    if (!pwm_out && pw_q && q_hi.size() > 0) chk("high", 34'(q_hi.pop_front()), 34'(cyc - t_rise));
    pw_q = pwm_out;
    if (cyc > 40000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] e);
    q_b.push_back(e);
    sw_u.wr(a, d);
  endtask : w
  task automatic r(input logic [ADDR_W-1:0] a, input logic [33:0] e);
    q_rd.push_back(e);
    sw_u.rd(a);
  endtask : r
  // settle three periods first: the first edge after a change is not a full cycle
  task automatic wave(input logic [31:0] c, input int per, input int hi);
    w(OFS_CTRL, c, RESP_OKAY);
    repeat (3 * per) @(posedge aclk);
    q_per = '{per, per};
    q_hi = '{hi, hi};
    w(OFS_CTRL, c ^ (32'h1 << CTL_FORCE), RESP_OKAY);
    repeat (3 * per) @(posedge aclk);
    chk("unseen", 34'(q_per.size() + q_hi.size()), 34'h0);
  endtask : wave
  task automatic lvl(input logic e);
    #1 chk("level", 34'(e), 34'(pwm_out));
    @(posedge aclk);
  endtask : lvl
  initial begin
    logic [31:0] v;
    void'($urandom(32'he279f202));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 5; i++) r(8'(4 * i), 34'h0);
    r(8'h14, {32'h0, RESP_SLVERR});
    w(OFS_STATUS, 32'h1, RESP_SLVERR);
    w(8'h40, 32'h1, RESP_SLVERR);
    for (int i = 1; i < 4; i++) begin
      v = $urandom();
      w(8'(4 * i), v, RESP_OKAY);
      r(8'(4 * i), {16'h0, v[15:0], RESP_OKAY});
    end
    w(OFS_PERIOD, 32'h9, RESP_OKAY);
    w(OFS_PHASE, 32'h2, RESP_OKAY);
    w(OFS_DUTY, 32'h6, RESP_OKAY);
    for (int p = 0; p < 4; p++) wave(32'h1 | (p << 4), 10 << (2 * p), 4 << (2 * p));
    ofs_on = 1'b1;
    wave(32'h41, 7, 4);
    ofs_on = 1'b0;
    w(OFS_PERIOD, 32'h4, RESP_OKAY);
    w(OFS_PHASE, 32'h0, RESP_OKAY);
    wave(32'hb, 10, 5);
    w(OFS_PHASE, 32'h1, RESP_OKAY);
    wave(32'h9, 20, 10);
    w(OFS_PERIOD, 32'h7, RESP_OKAY);
    w(OFS_DUTY, 32'h3, RESP_OKAY);
    wave(32'hf, 16, 6);
    w(OFS_PERIOD, 32'h5, RESP_OKAY);
    w(OFS_PHASE, 32'h3, RESP_OKAY);
    w(OFS_CTRL, 32'h5, RESP_OKAY);
    repeat (30) @(posedge aclk);
    lvl(1'b1);
    w(OFS_PHASE, 32'h9, RESP_OKAY);
    repeat (40) @(posedge aclk);
    lvl(1'b1);
    w(OFS_CTRL, 32'h5, RESP_OKAY);
    repeat (40) @(posedge aclk);
    lvl(1'b0);
    w(OFS_CTRL, 32'h7, RESP_OKAY);
    lvl(1'b1);
    w(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    lvl(1'b0);
    finish_test();
  end
endmodule : tb_top
